// ---- core/aclink_pkg.sv ----
// Constants for the AC-link lock, GP slot 12 shadow and slot enable block.
// Assumes a 16-bit APB byte address and 32-bit data.
package aclink_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [15:0] OFF_IRQ_STATUS = 16'hF710;
  localparam logic [15:0] OFF_IRQ_ENABLE = 16'hF714;
  localparam logic [15:0] OFF_IRQ_CLEAR  = 16'hF718;
  localparam logic [15:0] OFF_LOCK       = 16'hF720;
  localparam logic [15:0] OFF_GPI        = 16'hF740;
  localparam logic [15:0] OFF_GPO        = 16'hF744;
  localparam logic [15:0] OFF_SLT_EN     = 16'hF748;
  localparam logic [15:0] OFF_SLT_DIS    = 16'hF74C;

  // ----------------------------------------------------------------
  // Field positions, masks and reset values
  // ----------------------------------------------------------------
  localparam int unsigned LOCK_BIT     = 0;
  localparam int unsigned GPO_PEND_BIT = 20;
  localparam int unsigned SLT_PEND_BIT = 16;
  localparam int unsigned GPI_SLT_BIT  = 9;
  localparam int unsigned GPO_SLT_BIT  = 8;
  localparam int unsigned MODI_SLT_BIT = 7;
  localparam int unsigned MODO_SLT_BIT = 6;
  localparam int unsigned GP_IRQ_BIT   = 0;
  localparam logic [31:0] GP_DATA_MASK = 32'h000FFFFE;
  localparam logic [31:0] GPI_MASK     = 32'h000FFFFF;
  localparam logic [3:0]  SLT_RST      = 4'h0;
  localparam logic [31:0] REG_RST      = 32'h00000000;

  // Interrupt status layout
  localparam int unsigned IRQ_GPO_DONE = 0;
  localparam int unsigned IRQ_SLT_DONE = 1;
  localparam int unsigned IRQ_GP       = 5;
  localparam logic [31:0] IRQ_MASK     = 32'h00000023;

  // ----------------------------------------------------------------
  // Link framing
  // ----------------------------------------------------------------
  localparam logic [7:0] FRAME_LAST   = 8'hFF;
  localparam logic [7:0] SLOT12_FIRST = 8'hEC;
  localparam logic [7:0] TAG_VALID    = 8'h00;
  localparam logic [7:0] TAG_SLOT12   = 8'h0C;
  localparam logic [4:0] SLOT_MSB     = 5'h13;
  localparam logic [7:0] CNT_ONE      = 8'h01;

endpackage

// ---- core/aclink_semaphore_gpio_slots.sv ----
// Driver lock, GP slot 12 shadow registers and slot enables of an AC-link
// controller, as an APB slave. Assumes the codec drives bit_clk, frame_sync
// and sdata_in asynchronously to pclk; bit_clk runs well below pclk / 4.
//
// How it works
// RQ1: Reading the lock while free returns 0 and takes the lock.
// RQ2: Reading the lock while held returns 1.
// RQ3: Any write to the lock register releases it.
// RQ4: Drivers take the lock before shared resources and release afterwards.
// RQ5: Received slot 12 bits 19..1 are shadowed into the GP input register.
// RQ6: Received slot 12 bit 0, the codec interrupt, shadowed into bit 0.
// RQ7: GP output bits 19..1 are sent in outgoing slot 12.
// RQ8: GP output bits 19..1 read back; bit 0 reads zero.
// RQ9: GP output pending bit 20 is high until the write reaches the link.
// RQ10: Software waits for GP output pending clear before writing again.
// RQ11: Slot pending bit 16 high until an enable or disable write applies.
// RQ12: Writing 1 to bit 9 enables GP input slot reception.
// RQ13: Writing 1 to bit 8 enables GP output slot transmission.
// RQ14: Writing 1 to bit 7 enables modem slot reception.
// RQ15: Writing 1 to bit 6 enables modem slot transmission.
// RQ16: GP interrupt flag set while rx bit 0 high; W1C only if low.
// RQ17: Writing 1 to disable bit 9 clears GP input reception enable.
// RQ18: Reading a held lock keeps it held and changes nothing else.
// RQ19: Reserved bits read zero and ignore writes.
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
module aclink_semaphore_gpio_slots (
  // APB clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // AC-link pins
  input  wire logic        bit_clk,
  input  wire logic        frame_sync,
  input  wire logic        sdata_in,
  output logic             sdata_out,
  // Slot stream enables to framing logic
  output logic             gp_in_slot_on,
  output logic             gp_out_slot_on,
  output logic             modem_rx_slot_on,
  output logic             modem_tx_slot_on,
  // Interrupt
  output logic             irq
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic reg_hit(input logic [15:0] a, input logic [15:0] off);
    reg_hit = (a == off);
  endfunction

  logic        pready_ff;
  logic        access;
  logic        rd_first;
  logic        wr_done;
  logic        rd_done;
  logic        hit_lock;
  logic        hit_gpi;
  logic        hit_gpo;
  logic        hit_en;
  logic        hit_dis;
  logic        hit_ist;
  logic        hit_ien;
  logic        hit_icl;
  logic        mapped;

  assign access   = psel & penable;
  // Read data is latched one cycle before the completing edge
  assign rd_first = access & ~pready_ff;
  assign wr_done  = access & pready_ff & pwrite;
  assign rd_done  = access & pready_ff & ~pwrite;
  assign hit_lock = reg_hit(paddr, aclink_pkg::OFF_LOCK);
  assign hit_gpi  = reg_hit(paddr, aclink_pkg::OFF_GPI);
  assign hit_gpo  = reg_hit(paddr, aclink_pkg::OFF_GPO);
  assign hit_en   = reg_hit(paddr, aclink_pkg::OFF_SLT_EN);
  assign hit_dis  = reg_hit(paddr, aclink_pkg::OFF_SLT_DIS);
  assign hit_ist  = reg_hit(paddr, aclink_pkg::OFF_IRQ_STATUS);
  assign hit_ien  = reg_hit(paddr, aclink_pkg::OFF_IRQ_ENABLE);
  assign hit_icl  = reg_hit(paddr, aclink_pkg::OFF_IRQ_CLEAR);
  assign mapped   = hit_lock | hit_gpi | hit_gpo | hit_en | hit_dis
                  | hit_ist | hit_ien | hit_icl;

  // ----------------------------------------------------------------
  // Link pin synchronisers and edge detect
  // ----------------------------------------------------------------
  logic [2:0] pin_s1_ff;
  logic [2:0] pin_s2_ff;
  logic       bclk_d_ff;
  logic       bclk_s;
  logic       sync_s;
  logic       sdin_s;
  logic       bclk_rise;
  logic       bclk_fall;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_ff <= 3'h0;
      pin_s2_ff <= 3'h0;
      bclk_d_ff <= 1'b0;
    end else begin
      pin_s1_ff <= {sdata_in, frame_sync, bit_clk};
      pin_s2_ff <= pin_s1_ff;
      bclk_d_ff <= pin_s2_ff[0];
    end
  end

  assign bclk_s    = pin_s2_ff[0];
  assign sync_s    = pin_s2_ff[1];
  assign sdin_s    = pin_s2_ff[2];
  assign bclk_rise = bclk_s & ~bclk_d_ff;
  assign bclk_fall = ~bclk_s & bclk_d_ff;

  // ----------------------------------------------------------------
  // Frame bit counter and slot 12 receiver
  // ----------------------------------------------------------------
  logic [7:0]  cnt_ff;
  logic        sync_prev_ff;
  logic [18:0] rx_sh_ff;
  logic [19:0] gpi_ff;
  logic        sync_rise;
  logic [7:0]  bit_idx;
  logic [7:0]  nxt_cnt;
  logic        frame_end;
  logic [19:0] rx_word;

  // Codec marks frame start with a rising sync sampled on a falling edge
  assign sync_rise = sync_s & ~sync_prev_ff;
  assign bit_idx   = sync_rise ? 8'h00 : cnt_ff;
  assign nxt_cnt   = bit_idx + aclink_pkg::CNT_ONE;
  assign frame_end = bclk_fall & (bit_idx == aclink_pkg::FRAME_LAST);
  assign rx_word   = {rx_sh_ff, sdin_s};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff       <= 8'h00;
      sync_prev_ff <= 1'b0;
      rx_sh_ff     <= 19'h00000;
    end else if (bclk_fall) begin
      cnt_ff       <= nxt_cnt;
      sync_prev_ff <= sync_s;
      rx_sh_ff     <= rx_word[18:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gpi_ff <= 20'h00000;
    end else if (frame_end && gp_in_slot_on) begin
      gpi_ff <= rx_word; // RQ5 RQ6
    end
  end

  // ----------------------------------------------------------------
  // GP output data and its pending handshake
  // ----------------------------------------------------------------
  logic [19:1] gpo_data_ff;
  logic [19:1] gpo_live_ff;
  logic        gpo_pend_ff;
  logic        gpo_wr;
  logic        gpo_apply;

  assign gpo_wr    = wr_done & hit_gpo;
  assign gpo_apply = frame_end & gpo_pend_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gpo_data_ff <= 19'h00000;
      gpo_live_ff <= 19'h00000;
      gpo_pend_ff <= 1'b0;
    end else begin
      if (gpo_wr) begin
        gpo_data_ff <= pwdata[19:1]; // RQ8
      end
      if (gpo_apply) begin
        gpo_live_ff <= gpo_data_ff; // RQ7
      end
      // A new write beats a frame boundary in the same cycle
      gpo_pend_ff <= gpo_wr | (gpo_pend_ff & ~frame_end); // RQ9
    end
  end

  // ----------------------------------------------------------------
  // Slot enables: register view is immediate, link view at frame end
  // ----------------------------------------------------------------
  logic [3:0] slt_en_ff;
  logic [3:0] slt_live_ff;
  logic       slt_pend_ff;
  logic [3:0] set_bits;
  logic [3:0] clr_bits;
  logic [3:0] nxt_slt_en;
  logic       slt_wr;

  // Order of the four bits: GP in, GP out, modem rx, modem tx
  assign set_bits = (wr_done & hit_en) ?
                    {pwdata[aclink_pkg::GPI_SLT_BIT], pwdata[aclink_pkg::GPO_SLT_BIT],
                     pwdata[aclink_pkg::MODI_SLT_BIT], pwdata[aclink_pkg::MODO_SLT_BIT]}
                    : 4'h0;
  assign clr_bits = (wr_done & hit_dis) ?
                    {pwdata[aclink_pkg::GPI_SLT_BIT], pwdata[aclink_pkg::GPO_SLT_BIT],
                     pwdata[aclink_pkg::MODI_SLT_BIT], pwdata[aclink_pkg::MODO_SLT_BIT]}
                    : 4'h0;
  assign nxt_slt_en = (slt_en_ff | set_bits) & ~clr_bits; // RQ12 RQ13 RQ14 RQ15 RQ17
  assign slt_wr     = wr_done & (hit_en | hit_dis);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slt_en_ff   <= aclink_pkg::SLT_RST;
      slt_live_ff <= aclink_pkg::SLT_RST;
      slt_pend_ff <= 1'b0;
    end else begin
      slt_en_ff <= nxt_slt_en;
      if (frame_end) begin
        slt_live_ff <= slt_en_ff;
      end
      slt_pend_ff <= slt_wr | (slt_pend_ff & ~frame_end); // RQ11
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gp_in_slot_on    <= 1'b0;
      gp_out_slot_on   <= 1'b0;
      modem_rx_slot_on <= 1'b0;
      modem_tx_slot_on <= 1'b0;
    end else begin
      {gp_in_slot_on, gp_out_slot_on, modem_rx_slot_on, modem_tx_slot_on} <= slt_live_ff;
    end
  end

  // ----------------------------------------------------------------
  // Serial output: tag bits and slot 12
  // ----------------------------------------------------------------
  logic [4:0] slot_pos;
  logic [4:0] gpo_idx;
  logic       in_slot12;
  logic       nxt_sdout;

  // cnt_ff holds the index the codec samples on the coming falling edge
  assign in_slot12 = (cnt_ff >= aclink_pkg::SLOT12_FIRST);
  assign slot_pos  = 5'(cnt_ff - aclink_pkg::SLOT12_FIRST);
  assign gpo_idx   = aclink_pkg::SLOT_MSB - slot_pos;
  assign nxt_sdout = gp_out_slot_on &
                     ((cnt_ff == aclink_pkg::TAG_VALID) |
                      (cnt_ff == aclink_pkg::TAG_SLOT12) |
                      (in_slot12 & (gpo_idx != 5'h00) &
                       gpo_live_ff[gpo_idx])); // RQ7

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sdata_out <= 1'b0;
    end else if (bclk_rise) begin
      sdata_out <= nxt_sdout;
    end
  end

  // ----------------------------------------------------------------
  // Driver lock
  // ----------------------------------------------------------------
  logic lock_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_ff <= 1'b0;
    end else if (wr_done && hit_lock) begin
      lock_ff <= 1'b0; // RQ3
    end else if (rd_done && hit_lock) begin
      // Held lock stays held; a free one is taken by this read
      lock_ff <= 1'b1; // RQ1 RQ18
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status, enable and clear
  // ----------------------------------------------------------------
  logic [31:0] ist_ff;
  logic [31:0] ien_ff;
  logic [31:0] ev_set;
  logic [31:0] ev_clr;
  logic        gp_clr_ok;

  // The codec interrupt flag cannot be cleared while the line is still high
  assign gp_clr_ok = ~gpi_ff[aclink_pkg::GP_IRQ_BIT];
  assign ev_set = (32'(gpo_apply) << aclink_pkg::IRQ_GPO_DONE)
                | (32'(frame_end & slt_pend_ff) << aclink_pkg::IRQ_SLT_DONE)
                | (32'(gpi_ff[aclink_pkg::GP_IRQ_BIT]) << aclink_pkg::IRQ_GP); // RQ16
  assign ev_clr = (wr_done & hit_icl) ?
                  (pwdata & aclink_pkg::IRQ_MASK &
                   ~(32'(!gp_clr_ok) << aclink_pkg::IRQ_GP)) : 32'h00000000; // RQ16

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ist_ff <= aclink_pkg::REG_RST;
      ien_ff <= aclink_pkg::REG_RST;
      irq    <= 1'b0;
    end else begin
      // Set wins over a clear in the same cycle
      ist_ff <= (ist_ff & ~ev_clr) | ev_set;
      if (wr_done && hit_ien) begin
        ien_ff <= pwdata & aclink_pkg::IRQ_MASK;
      end
      irq <= |(ist_ff & ien_ff);
    end
  end

  // ----------------------------------------------------------------
  // Read mux and APB response
  // ----------------------------------------------------------------
  logic [31:0] rd_lock;
  logic [31:0] rd_gpi;
  logic [31:0] rd_gpo;
  logic [31:0] rd_en;
  logic [31:0] rd_val;

  assign rd_lock = 32'(lock_ff) << aclink_pkg::LOCK_BIT; // RQ1 RQ2
  assign rd_gpi  = 32'(gpi_ff) & aclink_pkg::GPI_MASK; // RQ19
  assign rd_gpo  = (32'(gpo_pend_ff) << aclink_pkg::GPO_PEND_BIT)
                 | ({12'h000, gpo_data_ff, 1'b0} & aclink_pkg::GP_DATA_MASK); // RQ8 RQ9
  assign rd_en   = (32'(slt_pend_ff) << aclink_pkg::SLT_PEND_BIT)
                 | (32'(slt_en_ff[3]) << aclink_pkg::GPI_SLT_BIT)
                 | (32'(slt_en_ff[2]) << aclink_pkg::GPO_SLT_BIT)
                 | (32'(slt_en_ff[1]) << aclink_pkg::MODI_SLT_BIT)
                 | (32'(slt_en_ff[0]) << aclink_pkg::MODO_SLT_BIT); // RQ11 RQ19
  assign rd_val  = hit_lock ? rd_lock :
                   hit_gpi  ? rd_gpi  :
                   hit_gpo  ? rd_gpo  :
                   hit_en   ? rd_en   :
                   hit_ist  ? ist_ff  :
                   hit_ien  ? ien_ff  : 32'h00000000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      prdata    <= 32'h00000000;
      pslverr   <= 1'b0;
    end else begin
      pready_ff <= rd_first;
      pslverr   <= rd_first & ~mapped;
      if (rd_first && !pwrite) begin
        prdata <= rd_val;
      end
    end
  end

  assign pready = pready_ff;

endmodule

// ---- tb/aclink_semaphore_gpio_slots_sva.sv ----
// Checker for the lock, GP slot 12 and slot enable block, on its APB ports.
// Assumes one pclk domain; bound from the testbench top.
`timescale 1ns/1ps
module aclink_semaphore_gpio_slots_sva (
  // APB
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready
);
  // ------------------------------------------------
  // Shadow of completed transfers
  // ------------------------------------------------
  logic        done, wr, lock_rd, gpo_rd, gpi_rd, sen_rd, lock_ff;
  logic [19:1] gpo_ff;
  logic [3:0]  slt_ff;
  assign done    = psel & penable & pready;
  assign wr      = done & pwrite;
  assign lock_rd = done & !pwrite & (paddr == aclink_pkg::OFF_LOCK);
  assign gpo_rd  = done & !pwrite & (paddr == aclink_pkg::OFF_GPO);
  assign gpi_rd  = done & !pwrite & (paddr == aclink_pkg::OFF_GPI);
  assign sen_rd  = done & !pwrite & (paddr == aclink_pkg::OFF_SLT_EN);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_ff <= 1'h0;
      gpo_ff  <= '0;
      slt_ff  <= 4'h0;
    end else begin
      if (done && paddr == aclink_pkg::OFF_LOCK) lock_ff <= !pwrite;
      if (wr && paddr == aclink_pkg::OFF_GPO) gpo_ff <= pwdata[19:1];
      if (wr && paddr == aclink_pkg::OFF_SLT_EN) slt_ff <= slt_ff | pwdata[9:6];
      if (wr && paddr == aclink_pkg::OFF_SLT_DIS) slt_ff <= slt_ff & ~pwdata[9:6];
    end
  end
  // ------------------------------------------------
  // Assertions
  // ------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_lock_free_read: assert property (lock_rd && !lock_ff |-> prdata == 32'h0)
    else $error("free lock read not zero");
  a_lock_held_read: assert property (lock_rd && lock_ff |-> prdata == 32'h1)
    else $error("held lock read not one");
  a_gpo_read_back: assert property (gpo_rd |-> prdata[19:0] == {gpo_ff, 1'h0})
    else $error("output data readback wrong");
  a_gpo_reserved: assert property (gpo_rd |-> prdata[31:21] == 11'h0)
    else $error("output reserved bits set");
  a_gpi_reserved: assert property (gpi_rd |-> prdata[31:20] == 12'h0)
    else $error("input reserved bits set");
  a_slot_enables: assert property (sen_rd |-> prdata[9:6] == slt_ff)
    else $error("slot enable readback wrong");
  a_slot_reserved: assert property (sen_rd |-> {prdata[31:17], prdata[15:10]} == 21'h0)
    else $error("slot reserved bits set");
  a_ready_wait: assert property (psel && !penable ##1 penable |-> !pready ##1 pready)
    else $error("ready not in second access cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  c_lock_held: cover property (lock_rd && lock_ff);
  c_slot_pend: cover property (sen_rd && prdata[16]);
  c_gpo_pend: cover property (gpo_rd && prdata[20]);
endmodule

// ---- tb/aclink_codec_model.sv ----
// Behavioural codec: makes bit_clk, frame sync and incoming slot 12.
// Assumes the controller changes sdata_out after rising bit_clk.
`timescale 1ns/1ps
module aclink_codec_model (
  // Control from the bench
  input  wire logic        run,
  input  wire logic [19:0] gp_word,
  // Link pins
  input  wire logic        sdata_out,
  output logic             bit_clk,
  output logic             frame_sync,
  output logic             sdata_in,
  // Last outgoing slot 12 seen
  output logic      [19:0] gpo_seen,
  output int               frames
);
  int          idx;
  logic [19:0] cap;
  // Clock stops only between frames, so no frame is cut short
  initial begin
    bit_clk = 1'h0;
    frame_sync = 1'h0;
    sdata_in = 1'h0;
    gpo_seen = '0;
    cap = '0;
    idx = 0;
    frames = 0;
    forever begin
      #160;
      if (run || idx != 0) begin
        if (!bit_clk) begin
          frame_sync = (idx < 16);
          // Toggling filler outside slot 12 exposes misaligned sampling
          sdata_in = (idx >= 236) ? gp_word[255 - idx] : idx[0];
        end else begin
          cap = {cap[18:0], sdata_out};
          if (idx == 255) begin
            gpo_seen = cap;
            frames++;
          end
          idx = (idx + 1) % 256;
        end
        bit_clk = ~bit_clk;
      end
    end
  end
endmodule

// ---- tb/aclink_semaphore_gpio_slots_tb.sv ----
// Self-checking bench: APB master tasks, codec model and bound checker.
// Assumes aclink_pkg and the design from core/.
`timescale 1ns/1ps
module aclink_semaphore_gpio_slots_tb;
  // ------------------------------------------------
  // Signals and instances
  // ------------------------------------------------
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        bit_clk, frame_sync, sdata_in, sdata_out, irq, run;
  logic        gp_in_slot_on, gp_out_slot_on, modem_rx_slot_on, modem_tx_slot_on;
  logic [3:0]  slots;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [19:0] gp_word, gpo_seen;
  int          frames, fails, tests_run;
  assign slots = {gp_in_slot_on, gp_out_slot_on, modem_rx_slot_on, modem_tx_slot_on};
  aclink_semaphore_gpio_slots dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .bit_clk, .frame_sync, .sdata_in, .sdata_out,
    .gp_in_slot_on, .gp_out_slot_on, .modem_rx_slot_on, .modem_tx_slot_on, .irq);
  aclink_codec_model u_codec (.run, .gp_word, .sdata_out, .bit_clk, .frame_sync,
    .sdata_in, .gpo_seen, .frames);
  initial begin
    pclk = 1'h0;
    forever #20 pclk = ~pclk;
  end
  // ------------------------------------------------
  // Tasks
  // ------------------------------------------------
  task test_done;
    $display("mismatches %0d of %0d checks", fails, tests_run);
    if (fails == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task cut;
    fails++;
    $display("mismatch at %0t: wait ran out", $time);
    test_done();
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    rdat = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (pready !== 1'h1) cut();
  endtask
  task rd(input logic [15:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk(rdat, e);
  endtask
  // Software must wait for a pending bit before the next write
  task poll(input logic [15:0] a, input int b);
    int k;
    k = 0;
    do begin
      apb(1'h0, a, 32'h0);
      k++;
    end while (rdat[b] !== 1'h0 && k < 1000);
    if (k >= 1000) cut();
  endtask
  task wf(input int n);
    int f0, c;
    f0 = frames;
    c = 0;
    while (frames < f0 + n && c < 3000 * n) begin
      @(posedge pclk);
      c++;
    end
    if (c >= 3000 * n) begin
      cut();
    end else begin
      repeat (8) @(posedge pclk);
    end
  endtask
  task irq_is(input logic v);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, {31'h0, v});
  endtask
  // ------------------------------------------------
  // Sequence
  // ------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, run} = 5'h0;
    paddr = 16'h0;
    pwdata = 32'h0;
    gp_word = 20'hA5A5B;
    fails = 0;
    tests_run = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    rd(aclink_pkg::OFF_LOCK, 32'h0);
    rd(aclink_pkg::OFF_LOCK, 32'h1);
    rd(aclink_pkg::OFF_LOCK, 32'h1);
    apb(1'h1, aclink_pkg::OFF_LOCK, 32'hFFFFFFFE);
    rd(aclink_pkg::OFF_LOCK, 32'h0);
    apb(1'h1, aclink_pkg::OFF_LOCK, 32'h0);
    apb(1'h0, 16'hF730, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'h1, aclink_pkg::OFF_GPI, 32'hFFFFFFFF);
    rd(aclink_pkg::OFF_GPI, 32'h0);
    // Link stopped, so the enable write stays pending
    apb(1'h1, aclink_pkg::OFF_SLT_EN, 32'hFFFFFFE0);
    rd(aclink_pkg::OFF_SLT_EN, 32'h000103C0);
    chk({28'h0, slots}, 32'h0);
    run <= 1'h1;
    poll(aclink_pkg::OFF_SLT_EN, aclink_pkg::SLT_PEND_BIT);
    chk({28'h0, slots}, 32'hF);
    apb(1'h1, aclink_pkg::OFF_SLT_EN, 32'h0);
    rd(aclink_pkg::OFF_SLT_EN, 32'h000103C0);
    poll(aclink_pkg::OFF_SLT_EN, aclink_pkg::SLT_PEND_BIT);
    apb(1'h1, aclink_pkg::OFF_SLT_DIS, 32'h200);
    rd(aclink_pkg::OFF_SLT_EN, 32'h000101C0);
    poll(aclink_pkg::OFF_SLT_EN, aclink_pkg::SLT_PEND_BIT);
    chk({28'h0, slots}, 32'h7);
    apb(1'h1, aclink_pkg::OFF_SLT_EN, 32'h200);
    poll(aclink_pkg::OFF_SLT_EN, aclink_pkg::SLT_PEND_BIT);
    apb(1'h1, aclink_pkg::OFF_GPO, 32'hFFFFFFFF);
    rd(aclink_pkg::OFF_GPO, 32'h001FFFFE);
    poll(aclink_pkg::OFF_GPO, aclink_pkg::GPO_PEND_BIT);
    rd(aclink_pkg::OFF_GPO, 32'h000FFFFE);
    wf(1);
    chk({12'h0, gpo_seen}, 32'h000FFFFE);
    apb(1'h1, aclink_pkg::OFF_GPO, 32'h00055555);
    poll(aclink_pkg::OFF_GPO, aclink_pkg::GPO_PEND_BIT);
    wf(1);
    chk({12'h0, gpo_seen}, 32'h00055554);
    rd(aclink_pkg::OFF_GPI, 32'h000A5A5B);
    apb(1'h1, aclink_pkg::OFF_IRQ_ENABLE, 32'h20);
    irq_is(1'h1);
    apb(1'h1, aclink_pkg::OFF_IRQ_CLEAR, 32'h20);
    irq_is(1'h1);
    gp_word <= 20'h5A5A4;
    wf(2);
    rd(aclink_pkg::OFF_GPI, 32'h0005A5A4);
    irq_is(1'h1);
    apb(1'h1, aclink_pkg::OFF_IRQ_CLEAR, 32'h20);
    irq_is(1'h0);
    // Output-done and slot-done stay sticky; the codec flag is gone
    rd(aclink_pkg::OFF_IRQ_STATUS, 32'h00000003);
    test_done();
  end
endmodule
bind aclink_semaphore_gpio_slots aclink_semaphore_gpio_slots_sva u_sva (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready);
